//--- facc_cycle.sv
// One flash bus cycle (read or write) on the parallel pins.
// Assumes synchronous inputs; one cycle per start pulse.
`timescale 1ns/1ps
`include "facc_regs.svh"
module facc_cycle #(
    parameter int ACCESS_CYC = `FACC_ACCESS_CYC
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_start,
    input wire logic i_write,
    input wire logic [16:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic [7:0] i_flash_d,
    output facc_pkg::facc_pins_t o_pins,
    output logic [7:0] o_rdata,
    output logic o_done,
    output logic o_busy
);
    typedef enum logic [1:0]
    {
        FACC_CY_IDLE = 2'b00,
        FACC_CY_SETUP = 2'b01,
        FACC_CY_STROBE = 2'b11,
        FACC_CY_HOLD = 2'b10
    } facc_cy_state_t;

    facc_cy_state_t state_reg, state_next;
    logic [3:0] cnt_reg;
    logic write_reg;
    facc_pkg::facc_pins_t pins_reg;
    logic [7:0] rdata_reg;
    logic done_reg;
    wire cnt_zero = (cnt_reg == 4'h0);

    // ------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------
    // Address settles before strobes so capture on the later fall sees it
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            FACC_CY_IDLE: if (i_start) state_next = FACC_CY_SETUP;
            FACC_CY_SETUP: state_next = FACC_CY_STROBE;
            FACC_CY_STROBE: if (cnt_zero) state_next = FACC_CY_HOLD;
            FACC_CY_HOLD: state_next = FACC_CY_IDLE;
        endcase
    end

    // Pins: writes keep oe_n high, reads keep we_n high
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state_reg <= FACC_CY_IDLE;
            cnt_reg <= 4'h0;
            write_reg <= 1'b0;
            pins_reg <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 17'h0, dout: 8'h00, doe: 1'b0};
            rdata_reg <= 8'h00;
            done_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            done_reg <= (state_reg == FACC_CY_HOLD);
            unique case (state_reg)
                FACC_CY_IDLE:
                    if (i_start)
                    begin
                        write_reg <= i_write;
                        pins_reg.addr <= i_addr;
                        pins_reg.dout <= i_wdata;
                        pins_reg.doe <= i_write;
                    end
                FACC_CY_SETUP:
                begin
                    pins_reg.ce_n <= 1'b0;
                    pins_reg.we_n <= ~write_reg;
                    pins_reg.oe_n <= write_reg;
                    cnt_reg <= 4'(ACCESS_CYC);
                end
                FACC_CY_STROBE:
                begin
                    cnt_reg <= cnt_zero ? 4'h0 : cnt_reg - 4'h1;
                    if (cnt_zero)
                    begin
                        pins_reg.we_n <= 1'b1;
                        pins_reg.oe_n <= 1'b1;
                        pins_reg.ce_n <= 1'b1;
                        if (!write_reg) rdata_reg <= i_flash_d;
                    end
                end
                FACC_CY_HOLD: pins_reg.doe <= 1'b0;     // Data held past the rising edge
            endcase
        end
    end

    assign o_pins = pins_reg;
    assign o_rdata = rdata_reg;
    assign o_done = done_reg;
    assign o_busy = (state_reg != FACC_CY_IDLE);
endmodule : facc_cycle

//--- facc_flash_model.sv
// Behavioural flash answering identification and array reads.
// Assumes the host strobes follow the documented write and read cycles.
`timescale 1ns/1ps
`include "facc_regs.svh"
module facc_flash_model #(
    parameter logic [7:0] MAKER = 8'h5a, // Arbitrary value
    parameter logic [7:0] PART = 8'hc3, // Arbitrary value
    parameter logic [7:0] CONT = 8'h3c, // Arbitrary value
    parameter logic [4:0] PROT_SECT = 5'h1e
) (
    input wire logic i_ce_n,
    input wire logic i_oe_n,
    input wire logic i_we_n,
    input wire logic [16:0] i_addr,
    input wire logic [7:0] i_d,
    input wire logic i_a9_hv,
    output logic [7:0] o_d
);
    logic [16:0] lat_addr = 17'h00000;
    logic [1:0] step = 2'h0; // Array read at power up
    logic ident = 1'b0;
    logic wr_act = 1'b0;
    logic [7:0] last = 8'h00;
    logic [7:0] code;
    logic [7:0] prot;
    logic [7:0] ofs;
    logic [7:0] rd_val;
    // Address on the later falling strobe, only with outputs off
    always @(negedge i_we_n or negedge i_ce_n)
    begin
        if (!i_we_n && !i_ce_n && i_oe_n)
        begin
            wr_act = 1'b1;
            lat_addr = i_addr;
        end
    end
    // Command decode on the first rising strobe; any miss falls back
    always @(posedge i_we_n or posedge i_ce_n)
    begin
        if (wr_act)
        begin
            wr_act = 1'b0;
            ident = (i_d == `FACC_RESET_CMD) ? 1'b0 : ident | (step == 2'h2
                && lat_addr == `FACC_UNLOCK1_ADDR && i_d == `FACC_IDENT_CMD);
            step = (step == 2'h0 && lat_addr == `FACC_UNLOCK1_ADDR && i_d == `FACC_UNLOCK1_DATA)
                ? 2'h1 : (step == 2'h1 && lat_addr == `FACC_UNLOCK2_ADDR
                && i_d == `FACC_UNLOCK2_DATA) ? 2'h2 : 2'h0;
        end
    end
    // High voltage path maps A1:A0 onto the command-mode offsets
    assign ofs = i_a9_hv ? {3'h0, &i_addr[1:0], 2'h0, i_addr[1] & ~i_addr[0], i_addr[0]}
        : i_addr[7:0];
    // Protection never changes: no program, erase or unprotect pin modelled
    assign prot = (i_addr[16:12] == PROT_SECT) ? `FACC_PROT_YES : 8'h00;
    always_comb
    begin
        case (ofs)
            8'h00: code = MAKER;
            8'h01: code = PART;
            8'h02: code = prot;
            8'h11: code = CONT;
            default: code = 8'h00;
        endcase
    end
    assign rd_val = (ident || (i_a9_hv && !i_addr[6])) ? code
        : i_addr[7:0] ^ i_addr[15:8];
    // Released bus shows the inverse, never a stale match
    assign o_d = (!i_ce_n && !i_oe_n && i_we_n) ? rd_val : ~last;
    always @(posedge i_oe_n)
        last = rd_val;
endmodule : facc_flash_model

//--- facc_host.sv
// Host controller that drives a parallel flash into and out of identification mode.
// Assumes the flash pins are synchronous to i_clk and the flash honours its own rules.
`timescale 1ns/1ps
`include "facc_regs.svh"
module facc_host #(
    parameter int ACCESS_CYC = `FACC_ACCESS_CYC
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_req_valid,
    input facc_pkg::facc_req_t i_req,
    input wire logic i_hv_mode,
    input wire logic [7:0] i_flash_d,
    output logic o_req_ready,
    output logic o_resp_valid,
    output logic [7:0] o_resp_data,
    output logic o_resp_prot,
    output logic o_in_ident,
    output logic o_ce_n,
    output logic o_oe_n,
    output logic o_we_n,
    output logic [16:0] o_addr,
    output logic [7:0] o_d_out,
    output logic o_d_oe,
    output logic o_a9_hv
);
    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0]
    {
        FACC_IDLE = 3'b000,
        FACC_UNL1 = 3'b001,
        FACC_UNL2 = 3'b011,
        FACC_CMD = 3'b010,
        FACC_RD = 3'b110,
        FACC_WAIT = 3'b111
    } facc_state_t;

    facc_state_t state_reg, state_next;
    facc_pkg::facc_op_t op_reg;
    logic [16:0] addr_reg;
    logic [7:0] cmd_reg;
    logic ident_reg;
    logic resp_valid_reg;
    logic [7:0] resp_data_reg;
    logic resp_prot_reg;
    logic cy_start;
    logic cy_write;
    logic [16:0] cy_addr;
    logic [7:0] cy_wdata;
    logic [7:0] cy_rdata;
    logic cy_done;
    logic cy_busy;
    logic cy_write_done;
    facc_pkg::facc_pins_t cy_pins;

    // ------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------
    // Protection checks keep sector bits and swap in the protection offset; other requests keep the user's address
    wire is_enter = (i_req.op == facc_pkg::FACC_OP_IDENT_ENTER);
    wire is_reset = (i_req.op == facc_pkg::FACC_OP_RESET);
    wire [16:0] sect_bits = {i_req.addr[16:`FACC_SECT_LSB], {`FACC_SECT_LSB{1'b0}}};
    wire [16:0] ident_addr = (i_req.op == facc_pkg::FACC_OP_PROT_CHECK) ?
        (sect_bits | `FACC_OFS_PROT) : i_req.addr;
    // Entry command byte goes to the first unlock address, not the user's
    wire [16:0] take_addr = is_enter ? `FACC_UNLOCK1_ADDR : ident_addr;
    wire take = i_req_valid && o_req_ready;
    assign o_req_ready = (state_reg == FACC_IDLE);

    // Bus cycle selection per state
    assign cy_start = (state_reg != FACC_IDLE) && (state_reg != FACC_WAIT) && !cy_busy;
    assign cy_write = (state_reg != FACC_RD);
    assign cy_addr = (state_reg == FACC_UNL1) ? `FACC_UNLOCK1_ADDR :
                     (state_reg == FACC_UNL2) ? `FACC_UNLOCK2_ADDR : addr_reg;
    assign cy_wdata = (state_reg == FACC_UNL1) ? `FACC_UNLOCK1_DATA :
                      (state_reg == FACC_UNL2) ? `FACC_UNLOCK2_DATA : cmd_reg;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Each bus cycle is launched then awaited in WAIT via the return state
    facc_state_t ret_reg;
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            FACC_IDLE:
                if (take)
                    state_next = is_enter ? FACC_UNL1 :
                                 is_reset ? FACC_CMD : FACC_RD;
            FACC_UNL1, FACC_UNL2, FACC_CMD, FACC_RD:
                if (cy_start) state_next = FACC_WAIT;
            FACC_WAIT:
                if (cy_done) state_next = ret_reg;
            default: state_next = FACC_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state_reg <= FACC_IDLE;
            ret_reg <= FACC_IDLE;
            op_reg <= facc_pkg::FACC_OP_READ;
            addr_reg <= 17'h0;
            cmd_reg <= 8'h00;
            ident_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            if (take)
            begin
                op_reg <= i_req.op;
                addr_reg <= take_addr;
                cmd_reg <= is_reset ? `FACC_RESET_CMD : `FACC_IDENT_CMD;
            end
            if (cy_start)
                ret_reg <= (state_reg == FACC_UNL1) ? FACC_UNL2 :
                           (state_reg == FACC_UNL2) ? FACC_CMD : FACC_IDLE;
            // Mode flag follows completed command writes only
            if (cy_done && state_reg == FACC_WAIT && ret_reg == FACC_IDLE && cy_write_done)
                ident_reg <= (cmd_reg == `FACC_IDENT_CMD);
        end
    end

    // Remember whether the awaited cycle was a write
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            cy_write_done <= 1'b0;
        else if (cy_start)
            cy_write_done <= cy_write;
    end

    // ------------------------------------------------------------
    // Answer
    // ------------------------------------------------------------
    // Protection answer compares the whole code byte; only 01h means protected
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            resp_valid_reg <= 1'b0;
            resp_data_reg <= 8'h00;
            resp_prot_reg <= 1'b0;
        end
        else
        begin
            resp_valid_reg <= cy_done && !cy_write_done;
            if (cy_done && !cy_write_done)
            begin
                resp_data_reg <= cy_rdata;
                resp_prot_reg <= (op_reg == facc_pkg::FACC_OP_PROT_CHECK) &&
                                 (cy_rdata == `FACC_PROT_YES);
            end
        end
    end

    facc_cycle #(
        .ACCESS_CYC(ACCESS_CYC)
    ) u_cycle (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_start(cy_start),
        .i_write(cy_write),
        .i_addr(cy_addr),
        .i_wdata(cy_wdata),
        .i_flash_d(i_flash_d),
        .o_pins(cy_pins),
        .o_rdata(cy_rdata),
        .o_done(cy_done),
        .o_busy(cy_busy)
    );

    // Pin outputs; A9 elevation request only for high-voltage reads
    assign o_ce_n = cy_pins.ce_n;
    assign o_oe_n = cy_pins.oe_n;
    assign o_we_n = cy_pins.we_n;
    assign o_addr = cy_pins.addr;
    assign o_d_out = cy_pins.dout;
    assign o_d_oe = cy_pins.doe;
    assign o_a9_hv = i_hv_mode && !cy_pins.oe_n;
    assign o_resp_valid = resp_valid_reg;
    assign o_resp_data = resp_data_reg;
    assign o_resp_prot = resp_prot_reg;
    assign o_in_ident = ident_reg;
endmodule : facc_host

//--- facc_host_monitor.sv
// Checker for the flash identification host controller pins.
// Assumes binding to facc_host; sees only its ports.
`timescale 1ns/1ps
`include "facc_regs.svh"
module facc_host_monitor (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic o_ce_n,
    input wire logic o_oe_n,
    input wire logic o_we_n,
    input wire logic [16:0] o_addr,
    input wire logic [7:0] o_d_out,
    input wire logic o_d_oe,
    input wire logic o_a9_hv,
    input wire logic o_in_ident
);
    // ----------------------------------------
    // Strobe and mode relations
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    // One finished command write of a given byte
    sequence s_cmd_wr(logic [7:0] c);
        !o_we_n && o_d_out == c ##1 o_we_n;
    endsequence
    property p_enter;
        s_cmd_wr(`FACC_IDENT_CMD) |-> ##[0:8] o_in_ident;
    endproperty
    property p_exit;
        s_cmd_wr(`FACC_RESET_CMD) |-> ##[0:8] !o_in_ident;
    endproperty
    property p_wr_inh;
        !o_we_n |-> o_oe_n && !o_ce_n;
    endproperty
    property p_wr_drv;
        !o_we_n |-> o_d_oe;
    endproperty
    // Address and data must not move under a write strobe
    property p_hold;
        !o_we_n && !$past(o_we_n) |-> $stable(o_d_out) && $stable(o_addr);
    endproperty
    property p_hv;
        o_a9_hv |-> !o_oe_n && o_we_n && !o_ce_n;
    endproperty
    a_enter: assert property (p_enter) else $error("ident flag missing after command");
    a_exit: assert property (p_exit) else $error("ident flag stuck after reset command");
    a_wr_inh: assert property (p_wr_inh) else $error("write strobe without select");
    a_wr_drv: assert property (p_wr_drv) else $error("write strobe with bus released");
    a_hold: assert property (p_hold) else $error("write address or data moved");
    a_hv: assert property (p_hv) else $error("elevated A9 outside a read");
endmodule : facc_host_monitor

bind facc_host facc_host_monitor u_mon (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .o_ce_n(o_ce_n), .o_oe_n(o_oe_n), .o_we_n(o_we_n), .o_addr(o_addr),
    .o_d_out(o_d_out), .o_d_oe(o_d_oe), .o_a9_hv(o_a9_hv), .o_in_ident(o_in_ident));

//--- facc_host_tb.sv
// Self-checking bench for the flash identification host controller.
// Assumes facc_flash_model on the pins and the bound pin checker.
`timescale 1ns/1ps
module facc_host_tb;
    localparam logic [7:0] MAKER = 8'h5a; // Arbitrary value
    localparam logic [7:0] PART = 8'hc3; // Arbitrary value
    localparam logic [7:0] CONT = 8'h3c; // Arbitrary value
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_req_valid = 1'b0;
    facc_pkg::facc_req_t i_req = '0;
    logic i_hv_mode = 1'b0;
    logic [7:0] flash_d;
    logic req_ready, resp_valid, resp_prot, in_ident, ce_n, oe_n, we_n, d_oe, a9_hv;
    logic [16:0] addr;
    logic [7:0] resp_data, d_out, d;
    int err_count = 0;
    int total_checks = 0;
    always #12.5 i_clk = ~i_clk;
    facc_host dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_req_valid(i_req_valid),
        .i_req(i_req), .i_hv_mode(i_hv_mode), .i_flash_d(flash_d), .o_req_ready(req_ready),
        .o_resp_valid(resp_valid), .o_resp_data(resp_data), .o_resp_prot(resp_prot),
        .o_in_ident(in_ident), .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n), .o_addr(addr),
        .o_d_out(d_out), .o_d_oe(d_oe), .o_a9_hv(a9_hv));
    facc_flash_model #(.MAKER(MAKER), .PART(PART), .CONT(CONT), .PROT_SECT(5'h1e)) u_flash (
        .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_addr(addr), .i_d(d_out),
        .i_a9_hv(a9_hv), .o_d(flash_d));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // One request; waits for the answer of reads and for ready again
    task automatic do_op(input facc_pkg::facc_op_t op, input logic [16:0] a);
        int n;
        logic got;
        n = 0;
        got = (op == facc_pkg::FACC_OP_IDENT_ENTER || op == facc_pkg::FACC_OP_RESET);
        i_req_valid <= 1'b1;
        i_req <= '{op, a};
        @(posedge i_clk);
        i_req_valid <= 1'b0;
        do
        begin
            @(posedge i_clk);
            n++;
            if (resp_valid === 1'b1)
            begin
                d = resp_data;
                got = 1'b1;
            end
        end
        while (!(req_ready === 1'b1 && n > 1 && got) && n < 80);
        if (n >= 80)
        begin
            err_count++;
            $display("unexpected request end expected ready seen busy");
        end
    endtask : do_op
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_ident;
        logic [7:0] ofs [3] = '{8'h00, 8'h01, 8'h11};
        logic [7:0] exp [3] = '{MAKER, PART, CONT};
        do_op(facc_pkg::FACC_OP_IDENT_ENTER, 17'h00000);
        check("in_ident", {7'h00, in_ident}, 8'h01);
        for (int r = 0; r < 2; r++)
        begin
            for (int k = 0; k < 3; k++)
            begin
                do_op(facc_pkg::FACC_OP_IDENT_READ, {9'h1f3, ofs[k]});
                check("ident code", d, exp[k]);
            end
        end
        do_op(facc_pkg::FACC_OP_PROT_CHECK, 17'h1e000);
        check("prot byte", d, 8'h01);
        check("prot flag", {7'h00, resp_prot}, 8'h01);
        do_op(facc_pkg::FACC_OP_PROT_CHECK, 17'h08000);
        check("unprot flag", {7'h00, resp_prot}, 8'h00);
        check("unprot byte", d, 8'h00);
        do_op(facc_pkg::FACC_OP_RESET, 17'h1abcd);
        check("in_ident", {7'h00, in_ident}, 8'h00);
        do_op(facc_pkg::FACC_OP_READ, 17'h0a5c3);
        check("array byte", d, 8'ha5 ^ 8'hc3);
        $display("test ident done");
    endtask : t_ident
    task automatic t_hv;
        logic [7:0] exp [4] = '{MAKER, PART, 8'h01, CONT};
        i_hv_mode <= 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            do_op(facc_pkg::FACC_OP_READ, 17'h1e000 | 17'(k));
            check("hv code", d, exp[k]);
        end
        i_hv_mode <= 1'b0;
        $display("test hv done");
    endtask : t_hv
    // Host reset leaves the flash in ident; only the command gets it out
    task automatic t_rst;
        do_op(facc_pkg::FACC_OP_IDENT_ENTER, 17'h00000);
        i_reset_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_reset_n <= 1'b1;
        @(posedge i_clk);
        do_op(facc_pkg::FACC_OP_READ, 17'h00000);
        check("still ident", d, MAKER);
        do_op(facc_pkg::FACC_OP_RESET, 17'h00000);
        do_op(facc_pkg::FACC_OP_READ, 17'h13c5a);
        check("array byte", d, 8'h3c ^ 8'h5a);
        $display("test reset done");
    endtask : t_rst
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_of_test
    initial
    begin
        repeat (3) @(posedge i_clk);
        i_reset_n <= 1'b1;
        @(posedge i_clk);
        t_ident();
        t_hv();
        t_rst();
        end_of_test();
    end
    // Whole run needs about 250 cycles; the limit lies at 5000
    initial
    begin
        #(25 * 5000);
        err_count++;
        $display("unexpected watchdog expected done seen hang");
        end_of_test();
    end
endmodule : facc_host_tb

//--- facc_pkg.sv
// Types shared by the flash identification host controller.
// Assumes facc_regs.svh constants for the code values.
package facc_pkg;
    // Requests the user can make
    typedef enum logic [2:0]
    {
        FACC_OP_READ = 3'h0,
        FACC_OP_IDENT_ENTER = 3'h1,
        FACC_OP_IDENT_READ = 3'h2,
        FACC_OP_PROT_CHECK = 3'h3,
        FACC_OP_RESET = 3'h4
    } facc_op_t;

    // One request
    typedef struct packed
    {
        facc_op_t op;
        logic [16:0] addr;
    } facc_req_t;

    // Flash pins driven by the host
    typedef struct packed
    {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic [16:0] addr;
        logic [7:0] dout;
        logic doe;
    } facc_pins_t;
endpackage : facc_pkg

//--- facc_regs.svh
// Constants for the flash identification host controller.
// Assumes a byte-wide parallel flash with 17 address bits on the far side.
`ifndef FACC_REGS_SVH
`define FACC_REGS_SVH
// ------------------------------------------------------------
// Command codes and unlock cycles (fill from command table)
// ------------------------------------------------------------
`define FACC_UNLOCK1_ADDR 17'h00555
`define FACC_UNLOCK1_DATA 8'haa
`define FACC_UNLOCK2_ADDR 17'h002aa
`define FACC_UNLOCK2_DATA 8'h55
`define FACC_IDENT_CMD 8'h90
`define FACC_RESET_CMD 8'hf0
// ------------------------------------------------------------
// Identification offsets and answers
// ------------------------------------------------------------
`define FACC_OFS_MAKER 17'h00000
`define FACC_OFS_PART 17'h00001
`define FACC_OFS_PROT 17'h00002
`define FACC_OFS_CONT 17'h00011
`define FACC_PROT_YES 8'h01
`define FACC_SECT_LSB 12
// ------------------------------------------------------------
// Bus timing in cycles of the 25 ns clock
// ------------------------------------------------------------
`define FACC_CLK_NS 25
`define FACC_ACCESS_NS 90
`define FACC_ACCESS_CYC ((`FACC_ACCESS_NS + `FACC_CLK_NS - 1) / `FACC_CLK_NS)
`endif
